// file: core/reset_cause_and_vectoring.sv
/*
 * Reset-cause recording, program-entry vectoring, interrupt entry and
 * pin wake-up for a small 8-bit core, clocked by the instruction clock.
 * Assumes rst is the power-on reset, pins are asynchronous, and the core
 * supplies its next sequential or jump address on pc_next_in.
 */
// Operation
// - A power-on reset leaves the time-out flag at 1 and the power-down flag at 0.
// - A watchdog overflow reset clears both the time-out and power-down flags.
// - An external pin reset sets both the time-out and power-down flags.
// - After any reset, fetching restarts at address 0000h and system registers take defaults.
// - Any enabled interrupt that is taken sends execution to the one interrupt vector.
// - Interrupt entry pushes the next address from pc_next_in and then loads address 0008h.
// - The return-address stack holds four nested entries for calls and interrupts.
// - Three interrupt sources exist: two timers and the external pin on port0 bit0 with chosen edge.
// - A level change on any port0 or port1 pin wakes the device from low power, except port1 bit1 while it serves as reset.
// - Port1 bit1 is an input without pull-up when not used as reset, and also wakes on change.
`timescale 1ns/1ps
`default_nettype none
`include "rcv_defines.svh"

module reset_cause_and_vectoring
    import rcv_pkg::*;
#(
    parameter int PC_W        = `PC_WIDTH,
    parameter int STACK_DEPTH = `STACK_DEPTH_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst,                 // Power-on reset
    input  wire logic              reset_pin_mode,      // 1: port1 bit1 serves as reset
    input  wire logic              wdt_overflow,        // One-cycle pulse from watchdog
    input  wire logic [7:0]        port0_pins,
    input  wire logic [3:0]        port1_pins,
    input  wire logic              sleep_mode,
    input  wire logic              global_irq_en,
    input  wire logic [2:0]        irq_enable,
    input  wire logic [2:0]        irq_clear,
    input  wire edge_sel_type      irq_edge_select,
    input  wire logic              basic_timer_irq,
    input  wire logic              event_timer_irq,
    input  wire logic              instr_done,
    input  wire logic [PC_W-1:0]   pc_next_in,
    input  wire logic              call_in,
    input  wire logic              ret_in,
    output logic [PC_W-1:0]        fetch_addr,
    output logic                   defaults_load,
    output logic                   timeout_flag,
    output logic                   powerdown_flag,
    output logic [2:0]             irq_pending,
    output logic                   irq_taken,
    output logic                   wakeup,
    output logic                   port1_bit1_input,
    output logic                   port1_bit1_pullup_en
);

    // ============================================================
    // Pin synchronisers; logic reads stage two and its one-cycle-delayed copy prev_q
    logic [`PIN_COUNT-1:0] sync1_q;
    logic [`PIN_COUNT-1:0] sync2_q;
    logic [`PIN_COUNT-1:0] prev_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= `PIN_IDLE;
            sync2_q <= `PIN_IDLE;
            prev_q  <= `PIN_IDLE;
        end else begin
            sync1_q <= {port1_pins, port0_pins};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Reset sources; the pin is low-active and idles high
    logic ext_reset_active;
    logic reset_req;
    assign ext_reset_active = reset_pin_mode && !sync2_q[`RESET_PIN_BIT];
    assign reset_req        = ext_reset_active || wdt_overflow;

    // Pin without pull-up, never driven; reads low while it is the reset pin
    assign port1_bit1_input     = sync2_q[`RESET_PIN_BIT] && !reset_pin_mode;
    assign port1_bit1_pullup_en = 1'b0;

    // ============================================================
    // Reset-cause flags
    logic timeout_q;
    logic timeout_d;
    logic pdown_q;
    logic pdown_d;

    // External reset outranks a coincident watchdog pulse since it persists
    always_comb begin
        timeout_d = timeout_q;
        pdown_d   = pdown_q;
        if (ext_reset_active) begin
            timeout_d = `TIMEOUT_EXT;
            pdown_d   = `PDOWN_EXT;
        end else if (wdt_overflow) begin
            timeout_d = `TIMEOUT_WDT;
            pdown_d   = `PDOWN_WDT;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timeout_q <= `TIMEOUT_POR;
            pdown_q   <= `PDOWN_POR;
        end else begin
            timeout_q <= timeout_d;
            pdown_q   <= pdown_d;
        end
    end

    assign timeout_flag   = timeout_q;
    assign powerdown_flag = pdown_q;

    // ============================================================
    // Interrupt sources and wake-up
    logic [2:0] pend_q;
    logic [2:0] pend_d;
    logic [2:0] irq_evt;
    logic       ext_evt;
    logic       wake_q;
    logic       wake_d;
    logic [`PIN_COUNT-1:0] change_mask;

    // Edge choice on the external pin; a set always beats a clear
    always_comb begin
        unique case (irq_edge_select)
            EDGE_FALL: ext_evt = prev_q[`EXT_IRQ_BIT] && !sync2_q[`EXT_IRQ_BIT];
            EDGE_RISE: ext_evt = !prev_q[`EXT_IRQ_BIT] && sync2_q[`EXT_IRQ_BIT];
            EDGE_BOTH: ext_evt = prev_q[`EXT_IRQ_BIT] ^ sync2_q[`EXT_IRQ_BIT];
            default:   ext_evt = prev_q[`EXT_IRQ_BIT] && !sync2_q[`EXT_IRQ_BIT];
        endcase
        irq_evt                = `IRQ_NONE;
        irq_evt[`IRQ_BASIC_BIT] = basic_timer_irq;
        irq_evt[`IRQ_EVENT_BIT] = event_timer_irq;
        irq_evt[`IRQ_EXT_BIT]   = ext_evt;
        pend_d = (pend_q & ~irq_clear) | irq_evt;
        // Reset pin changes must not wake while it serves as reset
        change_mask                 = {`PIN_COUNT{1'b1}};
        change_mask[`RESET_PIN_BIT] = !reset_pin_mode;
        wake_d = sleep_mode && |((sync2_q ^ prev_q) & change_mask);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_q <= `IRQ_NONE;
            wake_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
            wake_q <= wake_d;
        end
    end

    assign irq_pending = pend_q;
    assign wakeup      = wake_q;

    // ============================================================
    // Program counter sequencing and stack
    return_stack_if #(.PC_W(PC_W), .DEPTH(STACK_DEPTH)) stk ();

    return_stack #(
        .DEPTH (STACK_DEPTH),
        .PC_W  (PC_W)
    ) u_stack (
        .clk   (clk),
        .rst   (rst),
        .stk   (stk)
    );

    phase_type       phase_q;
    phase_type       phase_d;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic            take;

    // Interrupts enter only between instructions, never during reset
    assign take = (phase_q == ST_RUN) && !reset_req && instr_done && global_irq_en && |(pend_q & irq_enable);

    // Reset beats interrupt, interrupt beats return, call and plain flow
    always_comb begin
        phase_d       = reset_req ? ST_HOLD : ST_RUN;
        pc_d          = pc_q;
        stk.push      = 1'b0;
        stk.pop       = 1'b0;
        stk.flush     = (phase_q == ST_HOLD) || reset_req;
        stk.push_addr = PC_W'(pc_q + 1'b1);
        if (reset_req || phase_q == ST_HOLD) begin
            pc_d = PC_W'(`RESET_VECTOR);
        end else if (take) begin
            stk.push      = 1'b1;
            stk.push_addr = pc_next_in;
            pc_d          = PC_W'(`IRQ_VECTOR);
        end else if (instr_done) begin
            if (ret_in) begin
                stk.pop = 1'b1;
                pc_d    = stk.top_addr;
            end else if (call_in) begin
                stk.push = 1'b1;
                pc_d     = pc_next_in;
            end else begin
                pc_d = pc_next_in;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= ST_HOLD;
            pc_q    <= PC_W'(`RESET_VECTOR);
        end else begin
            phase_q <= phase_d;
            pc_q    <= pc_d;
        end
    end

    assign fetch_addr    = pc_q;
    assign defaults_load = (phase_q == ST_HOLD);
    assign irq_taken     = take;

    // ============================================================
    // Checks
    property p_por_flags;
        @(posedge clk) disable iff (rst)
        (phase_q == ST_HOLD && $past(phase_q) == ST_HOLD && $past(timeout_q) && !$past(pdown_q) && !$past(reset_req))
            |-> (timeout_q && !pdown_q);
    endproperty
    a_por_flags: assert property (p_por_flags) else $error("power-on flags lost");

    property p_wdt_flags;
        @(posedge clk) disable iff (rst)
        (wdt_overflow && !ext_reset_active) |=> (!timeout_q && !pdown_q && defaults_load);
    endproperty
    a_wdt_flags: assert property (p_wdt_flags) else $error("watchdog flags wrong");

    property p_ext_flags;
        @(posedge clk) disable iff (rst)
        ext_reset_active |=> (timeout_q && pdown_q);
    endproperty
    a_ext_flags: assert property (p_ext_flags) else $error("external reset flags wrong");

    property p_reset_vector;
        @(posedge clk) disable iff (rst)
        reset_req |=> (fetch_addr == PC_W'(`RESET_VECTOR) && defaults_load && stk.level == '0);
    endproperty
    a_reset_vector: assert property (p_reset_vector) else $error("reset did not restart at zero");

    property p_irq_entry;
        @(posedge clk) disable iff (rst)
        irq_taken |=> (fetch_addr == PC_W'(`IRQ_VECTOR) && stk.top_addr == $past(pc_next_in));
    endproperty
    a_irq_entry: assert property (p_irq_entry) else $error("interrupt entry wrong");

    property p_irq_only_enabled;
        @(posedge clk) disable iff (rst)
        irq_taken |-> (global_irq_en && |(irq_pending & irq_enable));
    endproperty
    a_irq_only_enabled: assert property (p_irq_only_enabled) else $error("interrupt taken while disabled");

    property p_ext_edge;
        @(posedge clk) disable iff (rst)
        (irq_edge_select == EDGE_FALL && $past(sync2_q[`EXT_IRQ_BIT]) && !sync2_q[`EXT_IRQ_BIT] && prev_q[`EXT_IRQ_BIT])
            |=> irq_pending[`IRQ_EXT_BIT];
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("external edge not pended");

    property p_wake;
        @(posedge clk) disable iff (rst)
        (sleep_mode && sync2_q[7:0] != prev_q[7:0]) |=> wakeup;
    endproperty
    a_wake: assert property (p_wake) else $error("port change did not wake");

    property p_flags_hold;
        @(posedge clk) disable iff (rst)
        !reset_req |=> ($stable(timeout_q) && $stable(pdown_q));
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("reset flags changed without reset");

endmodule : reset_cause_and_vectoring

`default_nettype wire

// file: common/rcv_defines.svh
/*
 * Constants for the reset-cause and program-entry vectoring block:
 * vectors, widths, reset-cause flag values and pin idle levels.
 * Assumes nothing; definitions only, included by bare name.
 */
`ifndef RCV_DEFINES_SVH
`define RCV_DEFINES_SVH

// ============================================================
// Program space
`define PC_WIDTH          10
`define RESET_VECTOR      10'h000
`define IRQ_VECTOR        10'h008
`define STACK_DEPTH_DEF   4

// ============================================================
// Reset-cause flag values (time-out, power-down)
`define TIMEOUT_POR       1'b1
`define PDOWN_POR         1'b0
`define TIMEOUT_WDT       1'b0
`define PDOWN_WDT         1'b0
`define TIMEOUT_EXT       1'b1
`define PDOWN_EXT         1'b1

// ============================================================
// Pin field layout and idle level (port0 in 7:0, port1 in 11:8)
`define PIN_COUNT         12
`define PIN_IDLE          12'hFFF
`define EXT_IRQ_BIT       0
`define RESET_PIN_BIT     9

// ============================================================
// Interrupt pending bit positions
`define IRQ_BASIC_BIT     0
`define IRQ_EVENT_BIT     1
`define IRQ_EXT_BIT       2
`define IRQ_NONE          3'h0

`endif

// file: common/rcv_pkg.sv
/*
 * Types for the reset-cause and vectoring block.
 * Assumes rcv_defines.svh is on the include path.
 */
package rcv_pkg;

    // ============================================================
    // Edge choice for the external interrupt input
    typedef enum logic [1:0] {
        EDGE_FALL = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_BOTH = 2'b10
    } edge_sel_type;

    // ============================================================
    // Sequencer phase
    typedef enum logic {
        ST_HOLD = 1'b0,
        ST_RUN  = 1'b1
    } phase_type;

endpackage : rcv_pkg

// file: common/return_stack_if.sv
/*
 * Carrier between the vectoring logic and its return-address stack.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none

interface return_stack_if #(
    parameter int PC_W  = 10,
    parameter int DEPTH = 4
);
    logic                     push;
    logic                     pop;
    logic                     flush;
    logic [PC_W-1:0]          push_addr;
    logic [PC_W-1:0]          top_addr;
    logic [$clog2(DEPTH):0]   level;

    modport stack (input push, input pop, input flush, input push_addr, output top_addr, output level);
    modport user  (output push, output pop, output flush, output push_addr, input top_addr, input level);
endinterface : return_stack_if

`default_nettype wire

// file: core/return_stack.sv
/*
 * Return-address stack for calls and interrupts, flip-flop storage.
 * Assumes DEPTH is a power of two; deeper nesting wraps and overwrites
 * the oldest entry, so code that nests too deep loses its first return.
 */
`timescale 1ns/1ps
`default_nettype none

module return_stack #(
    parameter int DEPTH = 4,
    parameter int PC_W  = 10
) (
    input  wire logic      clk,
    input  wire logic      rst,
    return_stack_if.stack  stk
);
    localparam int PW = $clog2(DEPTH);

    logic [PC_W-1:0] mem_q [DEPTH];
    logic [PC_W-1:0] mem_d [DEPTH];
    logic [PW-1:0]   ptr_q;
    logic [PW-1:0]   ptr_d;
    logic [PW:0]     level_q;
    logic [PW:0]     level_d;

    // ============================================================
    // Next state: push writes at the pointer, pop steps back
    always_comb begin
        mem_d   = mem_q;
        ptr_d   = ptr_q;
        level_d = level_q;
        if (stk.flush) begin
            ptr_d   = '0;
            level_d = '0;
        end else if (stk.push) begin
            mem_d[ptr_q] = stk.push_addr;
            ptr_d        = ptr_q + 1'b1;
            if (level_q != (PW+1)'(DEPTH)) begin
                level_d = level_q + 1'b1;                 // Saturates at the nesting limit
            end
        end else if (stk.pop) begin
            ptr_d = ptr_q - 1'b1;
            if (level_q != '0) begin
                level_d = level_q - 1'b1;
            end
        end
    end

    // Register the stack
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            ptr_q   <= '0;
            level_q <= '0;
        end else begin
            mem_q   <= mem_d;
            ptr_q   <= ptr_d;
            level_q <= level_d;
        end
    end

    assign stk.top_addr = mem_q[ptr_q - 1'b1];
    assign stk.level    = level_q;

    // ============================================================
    // Checks
    property p_stack_bound;
        @(posedge clk) disable iff (rst)
        level_q <= (PW+1)'(DEPTH);
    endproperty
    a_stack_bound: assert property (p_stack_bound) else $error("stack level above depth");

    property p_stack_lifo;
        @(posedge clk) disable iff (rst)
        (stk.push && !stk.flush) |=> (stk.top_addr == $past(stk.push_addr));
    endproperty
    a_stack_lifo: assert property (p_stack_lifo) else $error("pushed address not on top");

endmodule : return_stack

`default_nettype wire

// file: sim/pin_partner.sv
/*
 * Model of the outside world at the pins: the shared reset pin and the
 * interrupt and wake-up pins of port0 and port1.
 * Assumes the bench commands it at rising clock edges; levels start idle high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rcv_defines.svh"

module pin_partner (
    input  wire logic        clk,
    input  wire logic        reset_req,
    input  wire logic [11:0] toggle_mask,
    output logic      [7:0]  port0_pins,
    output logic      [3:0]  port1_pins
);
    // ============================================================
    // Pin levels
    logic [11:0] level_q = `PIN_IDLE;

    // Idle level is high; each commanded bit flips once per edge
    always @(posedge clk) begin
        level_q <= level_q ^ toggle_mask;
    end

    // Reset pin stays high unless a reset is wanted, then it is pulled low
    always_comb begin
        {port1_pins, port0_pins} = level_q & ~(12'(reset_req) << `RESET_PIN_BIT);
    end
endmodule : pin_partner

`default_nettype wire

// file: sim/tb_top.sv
/*
 * Self-checking bench for reset causes, vectoring, interrupts and wake-up.
 * Assumes the pin partner model and the design's defaults for all parameters.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rcv_defines.svh"

module tb_top
    import rcv_pkg::*;
;
    // ============================================================
    // Signals
    localparam int DEPTH = `STACK_DEPTH_DEF;
    typedef struct {logic [1:0] kind; logic [11:0] val;} note_type;
    logic clk, rst, reset_pin_mode, wdt_overflow, sleep_mode, global_irq_en;
    logic basic_timer_irq, event_timer_irq, instr_done, call_in, ret_in, reset_req;
    logic [2:0]  irq_enable, irq_clear, irq_pending;
    logic [7:0]  port0_pins;
    logic [3:0]  port1_pins;
    logic [11:0] tgl;
    logic [9:0]  pc_next_in, fetch_addr, pc_m;
    logic        defaults_load, timeout_flag, powerdown_flag, irq_taken, wakeup;
    logic        port1_bit1_input, port1_bit1_pullup_en, dl_prev, done_prev, tk_prev;
    edge_sel_type irq_edge_select;
    note_type    notes[$];
    logic [9:0]  stk[$];
    int          bad_count, comparisons;

    pin_partner partner (.clk(clk), .reset_req(reset_req), .toggle_mask(tgl),
                         .port0_pins(port0_pins), .port1_pins(port1_pins));

    reset_cause_and_vectoring DUT (.clk(clk), .rst(rst), .reset_pin_mode(reset_pin_mode),
        .wdt_overflow(wdt_overflow), .port0_pins(port0_pins), .port1_pins(port1_pins),
        .sleep_mode(sleep_mode), .global_irq_en(global_irq_en), .irq_enable(irq_enable),
        .irq_clear(irq_clear), .irq_edge_select(irq_edge_select), .basic_timer_irq(basic_timer_irq),
        .event_timer_irq(event_timer_irq), .instr_done(instr_done), .pc_next_in(pc_next_in),
        .call_in(call_in), .ret_in(ret_in), .fetch_addr(fetch_addr), .defaults_load(defaults_load),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .irq_pending(irq_pending),
        .irq_taken(irq_taken), .wakeup(wakeup), .port1_bit1_input(port1_bit1_input),
        .port1_bit1_pullup_en(port1_bit1_pullup_en));

    // ============================================================
    // Clock, checks and closing
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : chk

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    // Oldest note is matched against each result as it appears
    task automatic take(input logic [1:0] kind, input logic [11:0] got);
        note_type n;
        if (notes.size() == 0) begin
            chk("spurious event", 14'h3FFF, {kind, got});
        end else begin
            n = notes.pop_front();
            chk("event", {n.kind, n.val}, {kind, got});
        end
    endtask : take

    // ============================================================
    // Monitor: sampled just after each edge so the edge's updates have landed
    always @(posedge clk) begin
        #1;
        if (!rst) begin
            if (dl_prev && !defaults_load) take(2'd1, {timeout_flag, powerdown_flag, fetch_addr});
            if (done_prev) take(2'd0, {1'b0, tk_prev, fetch_addr});
            if (wakeup === 1'b1) take(2'd2, 12'h000);
        end
        dl_prev = defaults_load;
        done_prev = (instr_done === 1'b1);
        tk_prev = irq_taken;
    end

    // ============================================================
    // Driver tasks and the return-stack model
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Oldest entry is lost on overflow, matching the wrapping stack
    function automatic void push(input logic [9:0] a);
        if (stk.size() == DEPTH) void'(stk.pop_front());
        stk.push_back(a);
    endfunction : push

    // op 0 flow, 1 call, 2 return, 3 interrupt entry
    task automatic exec(input int op);
        logic [9:0] t;
        t = 10'($urandom);
        @(posedge clk);
        instr_done <= 1'b1;
        call_in <= (op == 1);
        ret_in <= (op == 2);
        pc_next_in <= t;
        if (op == 0) pc_m = t;
        else if (op == 1) begin
            push(pc_m + 10'h001);
            pc_m = t;
        end else if (op == 2) pc_m = stk.pop_back();
        else begin
            push(t);
            pc_m = `IRQ_VECTOR;
        end
        notes.push_back('{2'd0, {1'b0, op == 3, pc_m}});
        @(posedge clk);
        instr_done <= 1'b0;
        call_in <= 1'b0;
        ret_in <= 1'b0;
    endtask : exec

    task automatic toggle(input int b);
        @(posedge clk);
        tgl <= 12'h001 << b;
        @(posedge clk);
        tgl <= 12'h000;
    endtask : toggle

    // ============================================================
    // Main sequence
    initial begin
        edge_sel_type eds[6];
        int           src[6];
        logic         hit[6];
        eds = '{EDGE_FALL, EDGE_FALL, EDGE_FALL, EDGE_RISE, EDGE_BOTH, EDGE_FALL};
        src = '{0, 1, 2, 2, 2, 2};
        hit = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        void'($urandom(32'h4227dbe4));
        {rst, reset_pin_mode, wdt_overflow, sleep_mode, global_irq_en} = 5'h10;
        {basic_timer_irq, event_timer_irq, instr_done, call_in, ret_in, reset_req} = 6'h00;
        {irq_enable, irq_clear, tgl, pc_next_in} = 28'h0;
        irq_edge_select = EDGE_FALL;
        {pc_m, bad_count, comparisons} = '0;
        notes.push_back('{2'd1, {`TIMEOUT_POR, `PDOWN_POR, `RESET_VECTOR}});
        tick(5);
        rst <= 1'b0;
        tick(4);
        // Plain flow, five nested calls (one wraps) and four returns
        exec(0);
        repeat (5) exec(1);
        repeat (4) exec(2);
        // Every interrupt source and every edge choice
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            irq_edge_select <= eds[i];
            irq_enable <= 3'b001 << src[i];
            global_irq_en <= 1'b1;
            @(posedge clk);
            basic_timer_irq <= (src[i] == 0);
            event_timer_irq <= (src[i] == 1);
            tgl <= {11'h000, src[i] == 2};
            @(posedge clk);
            {basic_timer_irq, event_timer_irq} <= 2'b00;
            tgl <= 12'h000;
            tick(5);
            chk("pending", {11'h000, 3'(hit[i]) << src[i]}, {11'h000, irq_pending});
            if (hit[i]) exec(3);
            @(posedge clk);
            irq_clear <= 3'b111;
            global_irq_en <= 1'b0;
            @(posedge clk);
            irq_clear <= 3'b000;
            if (hit[i]) exec(2);
        end
        // Wake-up on every port pin, port1 bit1 as plain input
        @(posedge clk);
        sleep_mode <= 1'b1;
        for (int b = 0; b < 12; b++) begin
            notes.push_back('{2'd2, 12'h000});
            toggle(b);
            tick(5);
            if (b == `RESET_PIN_BIT) chk("plain input", 14'h0, {13'h0, port1_bit1_input});
            notes.push_back('{2'd2, 12'h000});
            toggle(b);
            tick(5);
            if (b == `RESET_PIN_BIT) chk("plain input high", 14'h1, {13'h0, port1_bit1_input});
        end
        chk("pull-up", 14'h0, {13'h0, port1_bit1_pullup_en});
        // No wake while awake: a stray pulse finds an empty queue
        @(posedge clk);
        sleep_mode <= 1'b0;
        toggle(3);
        tick(5);
        toggle(3);
        tick(5);
        // External pin reset, then the flags must hold through normal work
        @(posedge clk);
        reset_pin_mode <= 1'b1;
        notes.push_back('{2'd1, {`TIMEOUT_EXT, `PDOWN_EXT, `RESET_VECTOR}});
        @(posedge clk);
        reset_req <= 1'b1;
        tick(6);
        reset_req <= 1'b0;
        tick(6);
        pc_m = `RESET_VECTOR;
        stk.delete();
        exec(0);
        exec(1);
        chk("held flags", 14'h3, {12'h0, timeout_flag, powerdown_flag});
        chk("reset pin input", 14'h0, {13'h0, port1_bit1_input});
        // Watchdog reset, then a power-on reset in mid-run
        notes.push_back('{2'd1, {`TIMEOUT_WDT, `PDOWN_WDT, `RESET_VECTOR}});
        @(posedge clk);
        wdt_overflow <= 1'b1;
        @(posedge clk);
        wdt_overflow <= 1'b0;
        tick(4);
        notes.push_back('{2'd1, {`TIMEOUT_POR, `PDOWN_POR, `RESET_VECTOR}});
        @(posedge clk);
        rst <= 1'b1;
        tick(3);
        rst <= 1'b0;
        tick(6);
        chk("notes left", 14'h0, 14'(notes.size()));
        conclude();
    end

    // Run takes well under a thousand cycles
    initial begin
        #(25 * 5000);
        bad_count++;
        conclude();
    end
endmodule : tb_top

`default_nettype wire
